// ==== rtl/bfm_pkg.sv ====
// Purpose: Shared constants and types for the backlight fault monitor
// Assumes: 32-bit classic Wishbone register access, 50 MHz core clock
// Notes: Boost settings are codes in 0.25 V steps above 10 V
package bfm_pkg;
    localparam int NSTR = 7;
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_EXCLUDE = 8'h0C;
    localparam logic [7:0] OFS_LIVE = 8'h10;
    // Config field positions
    localparam int CFG_SEL_LO = 0;
    localparam int CFG_THR_LO = 2;
    localparam int CFG_UVL_BIT = 4;
    localparam logic [4:0] CFG_RESET = 5'h01;
    // Control field positions
    localparam int CTL_BL_BIT = 0;
    localparam int CTL_PSD_BIT = 1;
    localparam logic [1:0] CTL_RESET = 2'h0;
    // Status bit positions
    localparam int ST_AOPEN = 0;
    localparam int ST_ASHORT = 1;
    localparam int ST_DOPEN = 2;
    localparam int ST_DSHORT = 3;
    localparam int ST_UV = 4;
    localparam int ST_OC = 5;
    localparam int ST_TSD = 6;
    localparam int NST = 7;
    // Boost code scale: 0.25 V steps, 10 V origin; 38 V max is code 112
    localparam logic [6:0] BOOST_MAX_CODE = 7'h70;
    localparam int MV_PER_CODE = 250;
    localparam int HOP_BASE_MV = 3000;
    localparam int HOP_STEP_MV = 2000;
    // Fault detection method
    typedef enum logic [1:0] {
        FM_NONE = 2'h0, FM_ANALOG = 2'h1, FM_DIGITAL = 2'h2, FM_BOTH = 2'h3
    } bfm_mode_t;
endpackage

// ==== rtl/bfm_status_if.sv ====
// Purpose: Carries fault events and clears between the monitor modules
// Assumes: One clock domain
// Notes: ev is one bit per status position
`timescale 1ns/100ps
`default_nettype none
interface bfm_status_if;
    logic [6:0] ev;
    logic rd_clr;
    logic bl_clr;
    logic [6:0] flags;
    logic alarm_n;
    modport src (output ev, output rd_clr, output bl_clr, input flags, input alarm_n);
    modport dst (input ev, input rd_clr, input bl_clr, output flags, output alarm_n);
endinterface
`default_nettype wire

// ==== rtl/bfm_sync2.sv ====
// Purpose: Two flip-flop synchroniser for a bus of levels
// Assumes: Inputs asynchronous to CORE_CLK
// Notes: First stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module bfm_sync2 #(parameter int W = 1) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q, s1_d, s2_d;
    // Next values
    always_comb begin
        s1_d = d;
        s2_d = s1_q;
    end
    // Stage registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            q <= '0;
        end else begin
            s1_q <= s1_d;
            q <= s2_d;
        end
    end
endmodule // bfm_sync2
`default_nettype wire

// ==== rtl/bfm_status.sv ====
// Purpose: Sticky fault flags and one-shot alarm generation
// Assumes: Events are synchronous single-cycle or level
// Notes: Set wins over clear
`timescale 1ns/100ps
`default_nettype none
module bfm_status (
    input wire logic clk,
    input wire logic rst_n,
    bfm_status_if.dst sif
);
    import bfm_pkg::*;
    logic [NST-1:0] flags_q, flags_d, armed_q, armed_d;
    logic alarm_q, alarm_d;
    logic [NST-1:0] fire;
    // LED faults arm once per reset; supply and thermal faults always alarm
    always_comb begin
        fire = sif.ev & armed_q;
        armed_d = armed_q & ~(sif.ev & 7'h0F); // RULE_13
        flags_d = flags_q;
        if (sif.rd_clr || sif.bl_clr) flags_d = '0; // RULE_12 RULE_20
        flags_d = flags_d | sif.ev; // RULE_11 RULE_23
        alarm_d = alarm_q;
        if (sif.bl_clr) alarm_d = 1'b0; // RULE_20
        if (sif.rd_clr) alarm_d = 1'b0; // RULE_12
        if (|fire) alarm_d = 1'b1; // RULE_11 RULE_16 RULE_19
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= '0;
            armed_q <= 7'h7F;
            alarm_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            armed_q <= armed_d | 7'h70;
            alarm_q <= alarm_d;
        end
    end
    assign sif.flags = flags_q;
    assign sif.alarm_n = ~alarm_q;
endmodule // bfm_status
`default_nettype wire

// ==== rtl/bfm_monitor.sv ====
// Purpose: LED, supply and thermal fault monitor with Wishbone registers
// Assumes: Comparator and temperature inputs are asynchronous levels
// Notes: Reset by enable pin maps to RST_N
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01 - Two-bit method select: off, analog, digital, or both.
// RULE_02 - Analog mode watches every driver's headroom with Low/Mid/High comparators. Code uses only Low and High; Mid is synchronised but unused.
// RULE_03 - Collapsed pin with others above High is open; string then excluded.
// RULE_04 - Driver shorted to ground reports like an open string.
// RULE_05 - A pin above High while others are not flags a short.
// RULE_06 - Digital detection only in phase-shifted dimming, single string active.
// RULE_07 - Digital open needs 38 V setting and a large step to neighbour.
// RULE_08 - Digital short when a setting drops by more than the threshold.
// RULE_09 - Hop threshold field selects 3, 5, 7 or 9 volts.
// RULE_10 - Analog ignored with one string active; digital short only then.
// RULE_11 - Any fault pulls alarm low and sets its status bit.
// RULE_12 - Reading status clears the latched faults.
// RULE_13 - Each LED fault type alarms once until reset; still recorded.
// RULE_14 - Host should read status twice and trust matching reads.
// RULE_15 - Under-voltage level bit: 0 selects 6 V, 1 selects 3 V.
// RULE_16 - Under-voltage always watched; shuts down, alarms, sets bit.
// RULE_17 - Restart after under-voltage once input recovers, with hysteresis.
// RULE_18 - Boost over-current shuts down and sets its flag.
// RULE_19 - Over-temperature shuts down and alarms; resume below the low limit.
// RULE_20 - Refreshing backlight control high clears status and releases alarm.
// RULE_21 - Mid threshold sits 0.5 V above Low.
// RULE_22 - All asynchronous inputs are synchronised before use.
// RULE_23 - Status bits stay set until read or refresh.
module bfm_monitor (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Per-string comparators
    input wire logic [bfm_pkg::NSTR-1:0] HDR_BELOW_LOW,
    input wire logic [bfm_pkg::NSTR-1:0] HDR_ABOVE_MID,
    input wire logic [bfm_pkg::NSTR-1:0] HDR_ABOVE_HIGH,
    input wire logic [bfm_pkg::NSTR-1:0] STR_ACTIVE,
    // Adaptive boost setting of the string now being served
    input wire logic [6:0] BOOST_CODE,
    input wire logic BOOST_STEP,
    // Supply and thermal comparators
    input wire logic UV_TRIP_6V,
    input wire logic UV_TRIP_3V,
    input wire logic UV_CLEAR_6V,
    input wire logic UV_CLEAR_3V,
    input wire logic OVERCURRENT,
    input wire logic TEMP_HOT,
    input wire logic TEMP_COOL,
    // Outputs
    output logic FAULT_OUT,
    output logic FAULT_OE,
    output logic SHUTDOWN,
    output logic [bfm_pkg::NSTR-1:0] STR_EXCLUDE,
    output logic [2:0] MID_SEL
);
    import bfm_pkg::*;

    bfm_status_if sif ();

    // Synchronised inputs
    localparam int SW = 3 * NSTR + NSTR + 7 + 1;
    logic [SW-1:0] raw_s, sy;
    logic [NSTR-1:0] blow, amid, ahigh, act;
    logic uv6, uv3, uvc6, uvc3, oc, hot, cool;
    assign raw_s = {HDR_BELOW_LOW, HDR_ABOVE_MID, HDR_ABOVE_HIGH, STR_ACTIVE,
        UV_TRIP_6V, UV_TRIP_3V, UV_CLEAR_6V, UV_CLEAR_3V, OVERCURRENT, TEMP_HOT,
        TEMP_COOL, 1'b0};
    bfm_sync2 #(.W(SW)) u_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d(raw_s),
        .q(sy)
    ); // RULE_22
    assign {blow, amid, ahigh, act, uv6, uv3, uvc6, uvc3, oc, hot, cool} = sy[SW-1:1];

    bfm_status u_stat (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .sif(sif.dst)
    );

    // Count of set bits
    function automatic logic [3:0] popcnt(input logic [NSTR-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < NSTR; i++) c = c + {3'h0, v[i]};
        return c;
    endfunction

    // Hop threshold in boost codes
    function automatic logic [6:0] hop_codes(input logic [1:0] sel);
        int mv;
        mv = HOP_BASE_MV + HOP_STEP_MV * int'(sel);
        return 7'(mv / MV_PER_CODE);
    endfunction

    // Registers
    logic [4:0] cfg_q, cfg_d;
    logic [1:0] ctl_q, ctl_d;
    logic [NSTR-1:0] excl_q, excl_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    logic uv_q, uv_d, tsd_q, tsd_d, oc_q, oc_d;
    logic [6:0] prev_q, prev_d;
    logic prev_v_q, prev_v_d;
    logic fout_q, fout_d, sd_q, sd_d;
    logic [NSTR-1:0] xo_q;
    logic [2:0] mid_q, mid_d;

    bfm_mode_t mode;
    logic [1:0] hop_sel;
    logic uvl_sel;
    logic ana_en, dig_en, single;
    logic [NSTR-1:0] a_open, a_short, live;
    logic d_open, d_short, uv_now, uv_back;
    logic [6:0] hop, diff_up, diff_dn;
    logic wb_go, wr, rd_stat;

    // Configuration decode
    always_comb begin
        mode = bfm_mode_t'(cfg_q[CFG_SEL_LO +: 2]); // RULE_01
        hop_sel = cfg_q[CFG_THR_LO +: 2];
        uvl_sel = cfg_q[CFG_UVL_BIT];
        hop = hop_codes(hop_sel); // RULE_09
        ana_en = (mode == FM_ANALOG) || (mode == FM_BOTH);
        dig_en = (mode == FM_DIGITAL) || (mode == FM_BOTH);
        single = (popcnt(act) == 4'h1);
    end

    // Analog detection across simultaneously active strings
    always_comb begin
        live = act & ~excl_q;
        a_open = '0;
        a_short = '0;
        if (ana_en && !single && popcnt(live) > 4'h1) begin // RULE_02 RULE_10
            for (int i = 0; i < NSTR; i++) begin
                // Collapsed or grounded pin, all others above High
                if (live[i] && blow[i] && ((ahigh | ~live | (7'h01 << i)) == 7'h7F))
                    a_open[i] = 1'b1; // RULE_03 RULE_04
                // Shorted LEDs: this pin alone above High
                if (live[i] && ahigh[i] && ((ahigh & live) == (7'h01 << i)))
                    a_short[i] = 1'b1; // RULE_05
            end
        end
    end

    // Digital detection on boost code hops between consecutive strings
    always_comb begin
        diff_up = BOOST_CODE - prev_q;
        diff_dn = prev_q - BOOST_CODE;
        d_open = 1'b0;
        d_short = 1'b0;
        if (dig_en && ctl_q[CTL_PSD_BIT] && single && BOOST_STEP && prev_v_q) begin // RULE_06
            if (BOOST_CODE >= BOOST_MAX_CODE && BOOST_CODE > prev_q && diff_up > hop)
                d_open = 1'b1; // RULE_07
            if (BOOST_CODE < prev_q && diff_dn > hop)
                d_short = 1'b1; // RULE_08 RULE_10
        end
        prev_d = BOOST_STEP ? BOOST_CODE : prev_q;
        prev_v_d = prev_v_q | BOOST_STEP;
    end

    // Supply, over-current and thermal shutdown
    always_comb begin
        uv_now = uvl_sel ? uv3 : uv6; // RULE_15
        uv_back = uvl_sel ? uvc3 : uvc6;
        uv_d = uv_q;
        if (uv_now) uv_d = 1'b1; // RULE_16
        else if (uv_back) uv_d = 1'b0; // RULE_17
        tsd_d = tsd_q;
        if (hot) tsd_d = 1'b1; // RULE_19
        else if (cool) tsd_d = 1'b0;
        oc_d = oc_q | oc; // RULE_18
        sd_d = uv_d | tsd_d | oc_d;
        excl_d = excl_q | a_open; // RULE_03
        mid_d = 3'h2; // RULE_21
    end

    // Wishbone slave and events
    always_comb begin
        wb_go = WB_CYC_I && WB_STB_I && !ack_q;
        wr = wb_go && WB_WE_I;
        rd_stat = wb_go && !WB_WE_I && (WB_ADR_I == OFS_STATUS);
        ack_d = wb_go;
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        dat_d = 32'h0;
        sif.bl_clr = 1'b0;
        if (wr && WB_SEL_I[0]) begin
            case (WB_ADR_I)
                OFS_CONFIG: cfg_d = WB_DAT_I[4:0];
                OFS_CONTROL: begin
                    ctl_d = WB_DAT_I[1:0];
                    sif.bl_clr = WB_DAT_I[CTL_BL_BIT]; // RULE_20
                end
                default: ;
            endcase
        end
        if (wb_go && !WB_WE_I) begin
            case (WB_ADR_I)
                OFS_CONFIG: dat_d = {27'h0, cfg_q};
                OFS_CONTROL: dat_d = {30'h0, ctl_q};
                OFS_STATUS: dat_d = {25'h0, sif.flags};
                OFS_EXCLUDE: dat_d = {25'h0, excl_q};
                OFS_LIVE: dat_d = {29'h0, oc_q, tsd_q, uv_q};
                default: dat_d = 32'h0;
            endcase
        end
        sif.rd_clr = rd_stat; // RULE_12
        sif.ev = '0;
        sif.ev[ST_AOPEN] = |a_open;
        sif.ev[ST_ASHORT] = |a_short;
        sif.ev[ST_DOPEN] = d_open;
        sif.ev[ST_DSHORT] = d_short;
        sif.ev[ST_UV] = uv_now; // RULE_16
        sif.ev[ST_OC] = oc; // RULE_18
        sif.ev[ST_TSD] = hot; // RULE_19
        fout_d = 1'b0;
    end

    // State registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cfg_q <= CFG_RESET;
            ctl_q <= CTL_RESET;
            excl_q <= '0;
            dat_q <= 32'h0;
            ack_q <= 1'b0;
            uv_q <= 1'b0;
            tsd_q <= 1'b0;
            oc_q <= 1'b0;
            prev_q <= 7'h0;
            prev_v_q <= 1'b0;
            fout_q <= 1'b0;
            sd_q <= 1'b0;
            xo_q <= '0;
            mid_q <= 3'h0;
        end else begin
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            excl_q <= excl_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
            uv_q <= uv_d;
            tsd_q <= tsd_d;
            oc_q <= oc_d;
            prev_q <= prev_d;
            prev_v_q <= prev_v_d;
            fout_q <= fout_d;
            sd_q <= sd_d;
            xo_q <= excl_d;
            mid_q <= mid_d;
        end
    end

    // Open-drain alarm: enable while pulling low
    logic fault_oe_q;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) fault_oe_q <= 1'b0;
        else fault_oe_q <= ~sif.alarm_n; // RULE_11
    end

    assign WB_DAT_O = dat_q;
    assign WB_ACK_O = ack_q;
    assign FAULT_OUT = fout_q;
    assign FAULT_OE = fault_oe_q;
    assign SHUTDOWN = sd_q;
    assign STR_EXCLUDE = xo_q;
    assign MID_SEL = mid_q;
endmodule // bfm_monitor
`default_nettype wire

// ==== sim/bfm_chk_monitor.sv ====
// Purpose: Port-level assertions for the fault monitor
// Assumes: Bound to bfm_monitor, one clock domain
// Notes: Figures follow the two-flop input synchroniser
`timescale 1ns/100ps
`default_nettype none
module bfm_chk (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic TEMP_HOT,
    input wire logic OVERCURRENT,
    input wire logic FAULT_OUT,
    input wire logic FAULT_OE,
    input wire logic SHUTDOWN,
    input wire logic [bfm_pkg::NSTR-1:0] STR_EXCLUDE,
    input wire logic [2:0] MID_SEL
);
    import bfm_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Bus answer one cycle after take, one cycle wide
    ack_latency_a:
        assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    ack_pulse_a:
        assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    // Open-drain alarm never drives high; Mid sits two steps above Low
    fault_level_a:
        assert property (FAULT_OUT == 1'b0) else $error("alarm driven high");
    mid_step_a:
        assert property ($past(RST_N) |-> MID_SEL == 3'h2) else $error("mid offset wrong");
    // Shutdown and alarm follow the synchronised hazard inputs
    hot_shutdown_a:
        assert property (TEMP_HOT [*4] |-> SHUTDOWN) else $error("no thermal shutdown");
    oc_shutdown_a:
        assert property (OVERCURRENT [*4] |-> SHUTDOWN) else $error("no overcurrent shutdown");
    hot_alarm_a:
        assert property ($rose(TEMP_HOT) ##1 TEMP_HOT [*4] |-> FAULT_OE) else $error("no alarm");
    // Excluded strings stay excluded until reset
    exclude_hold_a:
        assert property ($past(RST_N) |-> (STR_EXCLUDE & $past(STR_EXCLUDE)) == $past(STR_EXCLUDE))
            else $error("string re-included");
endmodule // bfm_chk
bind bfm_monitor bfm_chk u_chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .TEMP_HOT(TEMP_HOT), .OVERCURRENT(OVERCURRENT), .FAULT_OUT(FAULT_OUT),
    .FAULT_OE(FAULT_OE), .SHUTDOWN(SHUTDOWN), .STR_EXCLUDE(STR_EXCLUDE), .MID_SEL(MID_SEL)
);
`default_nettype wire

// ==== sim/bfm_led_model.sv ====
// Purpose: LED strings and adaptive boost as seen by the monitor
// Assumes: Commands change just after a rising edge
// Notes: Boost code is scrambled between step pulses
`timescale 1ns/100ps
`default_nettype none
module bfm_led_model (
    input wire logic clk,
    input wire logic [6:0] open_s,
    input wire logic [6:0] short_s,
    input wire logic [6:0] act,
    input wire logic hop_en,
    input wire logic [6:0] code_a,
    input wire logic [6:0] code_b,
    output logic [6:0] below_low,
    output logic [6:0] above_high,
    output logic [6:0] code,
    output logic step
);
    logic [2:0] cnt = 3'h0;
    logic ph = 1'b0;
    // Open pin collapses, others gain headroom; shorted LEDs raise their pin
    assign below_low = act & open_s;
    assign above_high = act & (short_s | ((act & open_s) != 7'h0 ? ~open_s : 7'h0));
    // Two settings alternate per served string, one step pulse each
    always_ff @(posedge clk) begin
        cnt <= hop_en ? cnt + 3'h1 : 3'h0;
        step <= hop_en && cnt == 3'h7;
        ph <= (hop_en && cnt == 3'h7) ? ~ph : ph;
        code <= (hop_en && cnt == 3'h7) ? (ph ? code_a : code_b) : ~code;
    end
endmodule // bfm_led_model
`default_nettype wire

// ==== sim/bfm_tb.sv ====
// Purpose: Directed bench for the backlight fault monitor
// Assumes: Wishbone answer one cycle after take
// Notes: Each scenario starts from a fresh reset
`timescale 1ns/100ps
`default_nettype none
module tb;
    import bfm_pkg::*;
    logic CORE_CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [7:0] WB_ADR_I;
    logic [31:0] WB_DAT_I, WB_DAT_O, rdat;
    logic [6:0] below_low, above_high, code, str_excl, open_s, short_s, act, code_a, code_b;
    logic step, hop_en, uv_t6, uv_t3, uv_c6, uv_c3, oc, hot, cool, f_out, f_oe, shut, fault_n;
    logic [2:0] mid_sel;
    int bad_count, n_compared;
    assign fault_n = f_oe ? f_out : 1'b1; // Pull-up on the open-drain alarm wire
    bfm_monitor DUT (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(4'hF), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .HDR_BELOW_LOW(below_low),
        .HDR_ABOVE_MID(above_high), .HDR_ABOVE_HIGH(above_high), .STR_ACTIVE(act),
        .BOOST_CODE(code), .BOOST_STEP(step), .UV_TRIP_6V(uv_t6), .UV_TRIP_3V(uv_t3),
        .UV_CLEAR_6V(uv_c6), .UV_CLEAR_3V(uv_c3), .OVERCURRENT(oc), .TEMP_HOT(hot),
        .TEMP_COOL(cool), .FAULT_OUT(f_out), .FAULT_OE(f_oe), .SHUTDOWN(shut),
        .STR_EXCLUDE(str_excl), .MID_SEL(mid_sel)
    );
    bfm_led_model LEDS (.clk(CORE_CLK), .open_s(open_s), .short_s(short_s), .act(act),
        .hop_en(hop_en), .code_a(code_a), .code_b(code_b), .below_low(below_low),
        .above_high(above_high), .code(code), .step(step));
    // Free-running 50 MHz core clock
    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic ck(input string w, input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", w, e, g);
            bad_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'h3, we};
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        @(posedge CORE_CLK);
        while (WB_ACK_O !== 1'b1 && n < 16) begin
            @(posedge CORE_CLK);
            n++;
        end
        rdat = WB_DAT_O;
        {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'h0;
        if (n == 16) begin
            bad_count++;
            close_out();
        end
        @(posedge CORE_CLK);
    endtask
    task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        ck(w, rdat, e);
    endtask
    task automatic rst();
        RST_N <= 1'b0;
        {open_s, short_s, act, code_a, code_b} <= '0;
        {hop_en, uv_t6, uv_t3, oc, hot} <= 5'h0;
        {uv_c6, uv_c3, cool} <= 3'h7;
        cyc(5);
        RST_N <= 1'b1;
        cyc(1);
    endtask
    task automatic t_regs();
        rst();
        rd("config", OFS_CONFIG, {27'h0, CFG_RESET});
        rd("status", OFS_STATUS, 32'h0);
        rd("exclude", OFS_EXCLUDE, 32'h0);
        rd("live", OFS_LIVE, 32'h0);
        wb(1'b1, 8'h14, 32'hFFFFFFFF);
        rd("unmapped", 8'h14, 32'h0);
        wb(1'b1, OFS_STATUS, 32'h7F);
        rd("status ro", OFS_STATUS, 32'h0);
        wb(1'b1, OFS_CONFIG, 32'h1B);
        rd("config rw", OFS_CONFIG, 32'h1B);
        ck("mid", 32'(mid_sel), 32'h2);
        $display("regs done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            rst();
            wb(1'b1, OFS_CONFIG, 32'(m));
            act <= 7'h7F;
            short_s <= 7'h04;
            cyc(8);
            ck("short alarm", 32'(!fault_n), 32'(m % 2));
            rd("short flag", OFS_STATUS, 32'(2 * (m % 2)));
        end
        $display("modes done");
    endtask
    task automatic t_open();
        rst();
        act <= 7'h7F;
        open_s <= 7'h10;
        cyc(3);
        ck("early alarm", 32'(fault_n), 32'h1);
        cyc(2);
        ck("open alarm", 32'(fault_n), 32'h0);
        ck("exclude", 32'(str_excl), 32'h10);
        open_s <= 7'h0;
        cyc(8);
        rd("open flag", OFS_STATUS, 32'h1);
        rd("cleared", OFS_STATUS, 32'h0);
        ck("alarm freed", 32'(fault_n), 32'h1);
        open_s <= 7'h20;
        cyc(8);
        ck("no realarm", 32'(fault_n), 32'h1);
        rd("reopen flag", OFS_STATUS, 32'h1);
        rd("excluded", OFS_EXCLUDE, 32'h30);
        $display("open done");
    endtask
    task automatic dig(input int t, input logic [6:0] a, input logic [6:0] b, input logic psd,
        input logic [31:0] m, input logic [31:0] e);
        rst();
        wb(1'b1, OFS_CONFIG, 32'(t * 4 + 2));
        wb(1'b1, OFS_CONTROL, {30'h0, psd, 1'b0});
        {act, code_a, code_b, hop_en} <= {7'h01, a, b, 1'b1};
        cyc(48);
        hop_en <= 1'b0;
        cyc(4);
        wb(1'b0, OFS_STATUS, 32'h0);
        ck("hop flags", rdat & m, e);
    endtask
    task automatic t_dig();
        for (int t = 0; t < 4; t++) begin
            int w;
            w = (HOP_BASE_MV + t * HOP_STEP_MV) / MV_PER_CODE;
            dig(t, 7'h50, 7'(80 - w), 1'b1, 32'h0C, 32'h0);
            dig(t, 7'h50, 7'(79 - w), 1'b1, 32'h0C, 32'h8);
        end
        dig(0, BOOST_MAX_CODE, 7'h63, 1'b1, 32'h4, 32'h4);
        dig(0, BOOST_MAX_CODE, 7'h6E, 1'b1, 32'h0C, 32'h0);
        dig(0, 7'h50, 7'h3C, 1'b0, 32'h0C, 32'h0);
        $display("digital done");
    endtask
    task automatic t_uv();
        rst();
        {uv_t6, uv_c6} <= 2'h2;
        cyc(6);
        ck("uv stop", 32'(shut), 32'h1);
        ck("uv alarm", 32'(fault_n), 32'h0);
        uv_t6 <= 1'b0;
        cyc(6);
        ck("uv hyst", 32'(shut), 32'h1);
        uv_c6 <= 1'b1;
        cyc(6);
        ck("uv run", 32'(shut), 32'h0);
        rd("uv flag", OFS_STATUS, 32'h10);
        wb(1'b1, OFS_CONFIG, 32'h11);
        {uv_t6, uv_c6} <= 2'h2;
        cyc(6);
        ck("uv 6v off", 32'(shut), 32'h0);
        {uv_t3, uv_c3} <= 2'h2;
        cyc(6);
        ck("uv 3v stop", 32'(shut), 32'h1);
        {uv_t6, uv_t3, uv_c6, uv_c3} <= 4'h3;
        cyc(6);
        wb(1'b1, OFS_CONTROL, 32'h1);
        ck("refresh alarm", 32'(fault_n), 32'h1);
        rd("refresh status", OFS_STATUS, 32'h0);
        $display("uv done");
    endtask
    task automatic t_hot();
        rst();
        {hot, cool} <= 2'h2;
        cyc(6);
        ck("hot stop", 32'(shut), 32'h1);
        ck("hot alarm", 32'(fault_n), 32'h0);
        hot <= 1'b0;
        cyc(6);
        ck("hot hold", 32'(shut), 32'h1);
        cool <= 1'b1;
        cyc(6);
        ck("hot run", 32'(shut), 32'h0);
        rd("hot flag", OFS_STATUS, 32'h40);
        oc <= 1'b1;
        cyc(6);
        oc <= 1'b0;
        cyc(6);
        ck("oc latch", 32'(shut), 32'h1);
        rd("oc flag", OFS_STATUS, 32'h20);
        rst();
        ck("oc reset", 32'(shut), 32'h0);
        $display("thermal done");
    endtask
    // Main sequence
    initial begin
        bad_count = 0;
        n_compared = 0;
        {WB_CYC_I, WB_STB_I, WB_WE_I} = 3'h0;
        WB_ADR_I = 8'h0;
        WB_DAT_I = 32'h0;
        t_regs();
        t_modes();
        t_open();
        t_dig();
        t_uv();
        t_hot();
        close_out();
    end
endmodule // tb
`default_nettype wire
